// File: lin_interp_defs.vh
`ifndef LIN_INTERP_DEFS_VH
`define LIN_INTERP_DEFS_VH

// Widths
`define POS_W        32
`define SPD_W        32
`define AXIS_W       3

// Axis numbering: 0 means axis undecided
`define AXIS_NONE    3'h0
`define AXIS_COUNT   3'h4

// Top bit of the square root, one result bit per cycle from here down
`define ROOT_MSB     6'h21

// Speed designation
`define SPD_MAIN     1'b0
`define SPD_SYNTH    1'b1

// Operating methods of a step
`define OPM_END      2'h0
`define OPM_KEEP     2'h1
`define OPM_CONT     2'h2

// Start commands
`define START_IND    2'h1
`define START_SYNC   2'h2

// Error codes
`define ERR_NONE     16'h0000
`define ERR_SUBAXIS  16'h00FD
`define ERR_ARCPOS   16'h0106

`endif

// File: lin_interp_speed.v
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Main-speed mode: sub speed equals main speed times sub over main travel.
// - Main-speed mode: path speed is root of sum of squared axis speeds.
// - Synthetic mode: main speed is path speed, axes scaled by travel/length.
// - Zero main travel: only sub moves, at the main axis's set speed.
// - Arc blend enable is checked at start: zero off, one on.
// - Arc distance from trace one end sets arc start and arc end.
// - Line to arc start, arc at same speed, then line at same speed.
// - End or Keep methods skip the arc, going straight to goal.
// - Arc distance above either trace length flags error 262, no arc.
// - Collinear traces get no arc.
// - 3-axis run starts only on indirect or synchronous start.
// - Absolute goals are taken from the homed origin.
// - Each axis runs forward if start below goal, reverse if above.
// - Undecided, self or out-of-range sub axis gives error 253.
// - One sub axis only: run a 2-axis interpolation.
`include "lin_interp_defs.vh"

module lin_interp_speed (
  input  wire                 clk_i,
  input  wire                 rst_n_i,
  input  wire [1:0]           start_i,
  input  wire [`AXIS_W-1:0]   main_axis_i,
  input  wire [`AXIS_W-1:0]   sub1_axis_i,
  input  wire [`AXIS_W-1:0]   sub2_axis_i,
  input  wire                 spd_mode_i,
  input  wire [`SPD_W-1:0]    op_speed_i,
  input  wire [1:0]           op_method_i,
  input  wire                 blend_en_i,
  input  wire [30:0]          arc_dist_i,
  input  wire [`POS_W-1:0]    cur_x_i,
  input  wire [`POS_W-1:0]    cur_y_i,
  input  wire [`POS_W-1:0]    cur_z_i,
  input  wire [`POS_W-1:0]    goal_x_i,
  input  wire [`POS_W-1:0]    goal_y_i,
  input  wire [`POS_W-1:0]    goal_z_i,
  input  wire [`POS_W-1:0]    next_x_i,
  input  wire [`POS_W-1:0]    next_y_i,
  output reg                  busy_o,
  output reg                  done_o,
  output reg  [15:0]          err_code_o,
  output reg  [`SPD_W-1:0]    rate_x_o,
  output reg  [`SPD_W-1:0]    rate_y_o,
  output reg  [`SPD_W-1:0]    rate_z_o,
  output reg  [`SPD_W-1:0]    path_speed_o,
  output reg  [2:0]           dir_fwd_o,
  output reg                  three_axis_o,
  output reg                  arc_en_o,
  output reg  [`POS_W-1:0]    arc_sx_o,
  output reg  [`POS_W-1:0]    arc_sy_o,
  output reg  [`POS_W-1:0]    arc_ex_o,
  output reg  [`POS_W-1:0]    arc_ey_o
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SQ   = 3'h1;
  localparam [2:0] S_SQRT = 3'h2;
  localparam [2:0] S_DIV  = 3'h3;
  localparam [2:0] S_OUT  = 3'h4;

  reg  [2:0]  state_ff;
  reg  [31:0] tx_ff, ty_ff, tz_ff;      // Travel magnitudes
  reg  [31:0] n2x_ff, n2y_ff;           // Next trace magnitudes
  reg  [66:0] sum_ff;                   // Radicand for path length
  reg  [33:0] root_ff;
  reg  [5:0]  bit_ff;
  reg         mode_ff, three_ff, blend_ff, colin_ff;
  reg  [31:0] spd_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Magnitude of a signed difference
  function [31:0] absdiff;
    input [31:0] a;
    input [31:0] b;
    reg   [31:0] d;
    begin
      d = a - b;
      absdiff = d[31] ? (~d + 32'h1) : d;
    end
  endfunction

  // Sub axis checks; undecided, equal to main or beyond module count
  wire s1_bad = (sub1_axis_i == `AXIS_NONE) || (sub1_axis_i == main_axis_i)
              || (sub1_axis_i > `AXIS_COUNT);
  wire s2_use = (sub2_axis_i != `AXIS_NONE);
  wire s2_bad = s2_use && ((sub2_axis_i == main_axis_i)
              || (sub2_axis_i > `AXIS_COUNT) || (sub2_axis_i == sub1_axis_i));
  wire start_ok = (start_i == `START_IND) || (start_i == `START_SYNC);

  // Candidate root bit for the restoring square root
  wire [67:0] trial = {34'h0, root_ff | (34'h1 << bit_ff)}
                    * {34'h0, root_ff | (34'h1 << bit_ff)};

  // Trace lengths as |dx|+|dy|, exact for axis-aligned traces only;
  // the spare bit keeps two full travels from wrapping
  wire        [32:0] len1   = {1'b0, tx_ff} + {1'b0, ty_ff};
  wire        [32:0] len2   = {1'b0, n2x_ff} + {1'b0, n2y_ff};

  // Signed trace vectors; magnitudes alone would call mirrored
  // diagonals collinear and lose the turn between them
  wire signed [32:0] d1x    = $signed({goal_x_i[31], goal_x_i})
                            - $signed({cur_x_i[31], cur_x_i});
  wire signed [32:0] d1y    = $signed({goal_y_i[31], goal_y_i})
                            - $signed({cur_y_i[31], cur_y_i});
  wire signed [32:0] d2x    = $signed({next_x_i[31], next_x_i})
                            - $signed({goal_x_i[31], goal_x_i});
  wire signed [32:0] d2y    = $signed({next_y_i[31], next_y_i})
                            - $signed({goal_y_i[31], goal_y_i});
  wire signed [65:0] cr_a   = d1x * d2y;
  wire signed [65:0] cr_b   = d1y * d2x;

  // Scaled speeds; only the low word is published, the host keeps
  // the speed low enough for it to hold the result
  wire        [63:0] p_x    = {32'h0, spd_ff} * {32'h0, tx_ff};
  wire        [63:0] p_y    = {32'h0, spd_ff} * {32'h0, ty_ff};
  wire        [63:0] p_z    = {32'h0, spd_ff} * {32'h0, tz_ff};
  wire        [63:0] p_p    = {32'h0, spd_ff} * {32'h0, root_ff[31:0]};
  wire        [63:0] syn_x  = p_x / {30'h0, root_ff};
  wire        [63:0] syn_y  = p_y / {30'h0, root_ff};
  wire        [63:0] syn_z  = p_z / {30'h0, root_ff};
  wire        [63:0] mn_y   = p_y / {32'h0, tx_ff};
  wire        [63:0] mn_z   = p_z / {32'h0, tx_ff};
  wire        [63:0] mn_p   = p_p / {32'h0, tx_ff};

  // Arc offsets from the corner; collinear or empty traces never
  // reach the divide, so a zero length is never a divisor
  wire        [63:0] dist64 = {33'h0, arc_dist_i};
  wire        [63:0] off_sx = (dist64 * {32'h0, tx_ff}) / {31'h0, len1};
  wire        [63:0] off_sy = (dist64 * {32'h0, ty_ff}) / {31'h0, len1};
  wire        [63:0] off_ex = (dist64 * {32'h0, n2x_ff}) / {31'h0, len2};
  wire        [63:0] off_ey = (dist64 * {32'h0, n2y_ff}) / {31'h0, len2};
  wire               nx_rev = $signed(next_x_i) < $signed(goal_x_i);
  wire               ny_rev = $signed(next_y_i) < $signed(goal_y_i);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: check, latch, norm, scale, publish
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff     <= S_IDLE;
      busy_o       <= 1'b0;
      done_o       <= 1'b0;
      err_code_o   <= `ERR_NONE;
      rate_x_o     <= 32'h0;
      rate_y_o     <= 32'h0;
      rate_z_o     <= 32'h0;
      path_speed_o <= 32'h0;
      dir_fwd_o    <= 3'h0;
      three_axis_o <= 1'b0;
      arc_en_o     <= 1'b0;
      arc_sx_o     <= 32'h0;
      arc_sy_o     <= 32'h0;
      arc_ex_o     <= 32'h0;
      arc_ey_o     <= 32'h0;
      tx_ff        <= 32'h0;
      ty_ff        <= 32'h0;
      tz_ff        <= 32'h0;
      n2x_ff       <= 32'h0;
      n2y_ff       <= 32'h0;
      sum_ff       <= 67'h0;
      root_ff      <= 34'h0;
      bit_ff       <= 6'h0;
      mode_ff      <= 1'b0;
      three_ff     <= 1'b0;
      blend_ff     <= 1'b0;
      colin_ff     <= 1'b0;
      spd_ff       <= 32'h0;
    end else begin
      done_o <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (start_ok && !busy_o) begin
            if (s1_bad || s2_bad) begin
              err_code_o <= `ERR_SUBAXIS;
              done_o     <= 1'b1;
              // A refused step must not show a stale arc or axis count
              arc_en_o     <= 1'b0;
              three_axis_o <= 1'b0;
            end else begin
              busy_o     <= 1'b1;
              err_code_o <= `ERR_NONE;
              // Absolute goals versus homed-origin positions
              tx_ff <= absdiff(goal_x_i, cur_x_i);
              ty_ff <= absdiff(goal_y_i, cur_y_i);
              tz_ff <= s2_use ? absdiff(goal_z_i, cur_z_i) : 32'h0;
              n2x_ff <= absdiff(next_x_i, goal_x_i);
              n2y_ff <= absdiff(next_y_i, goal_y_i);
              // Signed compare of start and goal
              dir_fwd_o <= {$signed(cur_z_i) < $signed(goal_z_i),
                            $signed(cur_y_i) < $signed(goal_y_i),
                            $signed(cur_x_i) < $signed(goal_x_i)};
              three_ff <= s2_use;
              mode_ff  <= spd_mode_i;
              spd_ff   <= op_speed_i;
              // Blend needs enable, continuous method, 2 axes
              blend_ff <= blend_en_i && (op_method_i == `OPM_CONT)
                          && !s2_use;
              state_ff <= S_SQ;
            end
          end
        end
        S_SQ: begin
          sum_ff  <= {35'h0, tx_ff} * {35'h0, tx_ff}
                   + {35'h0, ty_ff} * {35'h0, ty_ff}
                   + {35'h0, tz_ff} * {35'h0, tz_ff};
          root_ff <= 34'h0;
          bit_ff  <= `ROOT_MSB;
          colin_ff <= (cr_a == cr_b);
          state_ff <= S_SQRT;
        end
        S_SQRT: begin
          // One result bit per cycle keeps the multiplier small
          if (trial <= {1'b0, sum_ff})
            root_ff <= root_ff | (34'h1 << bit_ff);
          if (bit_ff == 6'h0)
            state_ff <= S_DIV;
          else
            bit_ff <= bit_ff - 6'h1;
        end
        S_DIV: begin
          if (mode_ff == `SPD_SYNTH && root_ff != 34'h0) begin
            rate_x_o <= syn_x[31:0];
            rate_y_o <= syn_y[31:0];
            rate_z_o <= syn_z[31:0];
            path_speed_o <= spd_ff;
          end else if (tx_ff == 32'h0) begin
            // Sub axis alone at the set speed
            rate_x_o <= 32'h0;
            rate_y_o <= (ty_ff != 32'h0) ? spd_ff : 32'h0;
            rate_z_o <= (tz_ff != 32'h0) ? spd_ff : 32'h0;
            path_speed_o <= spd_ff;
          end else begin
            // Sub may exceed main speed; host bounds it
            rate_x_o <= spd_ff;
            rate_y_o <= mn_y[31:0];
            rate_z_o <= mn_z[31:0];
            // Path speed is speed times norm over main travel
            path_speed_o <= mn_p[31:0];
          end
          state_ff <= S_OUT;
        end
        S_OUT: begin
          three_axis_o <= three_ff;
          arc_en_o     <= 1'b0;
          if (blend_ff && !colin_ff) begin
            if ({1'b0, arc_dist_i} > len1 || {1'b0, arc_dist_i} > len2)
              err_code_o <= `ERR_ARCPOS;
            else begin
              // Arc ends back off from the corner by the distance
              arc_en_o <= 1'b1;
              // Start lies back along trace one, end ahead along two
              arc_sx_o <= dir_fwd_o[0] ? goal_x_i - off_sx[31:0]
                                       : goal_x_i + off_sx[31:0];
              arc_sy_o <= dir_fwd_o[1] ? goal_y_i - off_sy[31:0]
                                       : goal_y_i + off_sy[31:0];
              arc_ex_o <= nx_rev ? goal_x_i - off_ex[31:0]
                                 : goal_x_i + off_ex[31:0];
              arc_ey_o <= ny_rev ? goal_y_i - off_ey[31:0]
                                 : goal_y_i + off_ey[31:0];
            end
          end
          busy_o   <= 1'b0;
          done_o   <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: lin_interp_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "lin_interp_defs.vh"
module lin_interp_chk (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [1:0]  start_i,
  input wire logic [2:0]  main_axis_i,
  input wire logic [2:0]  sub1_axis_i,
  input wire logic [2:0]  sub2_axis_i,
  input wire logic [1:0]  op_method_i,
  input wire logic        blend_en_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [15:0] err_code_o,
  input wire logic        three_axis_o,
  input wire logic        arc_en_o
);
  // Accepted start, and a first sub axis that cannot be used
  wire go = !busy_o && (start_i == `START_IND || start_i == `START_SYNC);
  wire bad = sub1_axis_i == `AXIS_NONE || sub1_axis_i == main_axis_i ||
             sub1_axis_i > `AXIS_COUNT;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RUN: assert property (
    go && !bad && sub2_axis_i == 3'h0 |=> busy_o ##37 done_o)
    else $error("run length wrong");
  AST_BAD_SUB: assert property (
    go && bad |=> done_o && err_code_o == `ERR_SUBAXIS)
    else $error("sub axis not refused");
  AST_IGNORED: assert property (
    !busy_o && (start_i == 2'h0 || start_i == 2'h3) |=> !busy_o)
    else $error("bad start code taken");
  AST_PULSE: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_NO_BLEND: assert property (
    done_o && (!blend_en_i || op_method_i != `OPM_CONT) |-> !arc_en_o)
    else $error("arc without blend");
  AST_ARC_ERR: assert property (
    done_o && err_code_o == `ERR_ARCPOS |-> !arc_en_o)
    else $error("arc kept on error");
  AST_TWO_AX: assert property (
    done_o && sub2_axis_i == `AXIS_NONE |-> !three_axis_o)
    else $error("three axes with one sub");
  // Results must stand while idle, or the host reads a moving value
  AST_HOLD: assert property (
    !busy_o && !go |=> $stable(err_code_o) && $stable(arc_en_o))
    else $error("result moved while idle");
  cover property (go && !bad);
  cover property (done_o && arc_en_o);
  cover property (done_o && err_code_o == `ERR_ARCPOS);
endmodule
bind lin_interp_speed lin_interp_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .start_i(start_i), .main_axis_i(main_axis_i), .sub1_axis_i(sub1_axis_i),
  .sub2_axis_i(sub2_axis_i), .op_method_i(op_method_i),
  .blend_en_i(blend_en_i), .busy_o(busy_o), .done_o(done_o),
  .err_code_o(err_code_o), .three_axis_o(three_axis_o), .arc_en_o(arc_en_o));
`default_nettype wire

// File: drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_model (
  input wire logic        clk_i,
  input wire logic        done_i,
  input wire logic [31:0] rate_i,
  output var logic [31:0] seen_o
);
  // A drive takes a new rate only when a step is published
  always @(posedge clk_i) begin
    if (done_i) begin
      seen_o <= rate_i;
    end
  end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lin_interp_defs.vh"
module tb;
  reg         clk_i = 0, rst_n_i = 0, md = 0, bl = 0;
  reg  [1:0]  st = 0, om = 0;
  reg  [2:0]  ma = 1, s1 = 2, s2 = 0;
  reg  [30:0] ad = 0;
  reg  [31:0] sp = 0, cx = 0, cy = 0, cz = 0, gx = 0, gy = 0, gz = 0;
  reg  [31:0] nx = 0, ny = 0;
  wire        bz, dn, t3, ae;
  wire [15:0] ec;
  wire [2:0]  df;
  wire [31:0] rx, ry, rz, ps, asx, asy, aex, aey, my;
  integer     err_count = 0, tests_run = 0, i;
  always #4 clk_i = ~clk_i;
  lin_interp_speed dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(st),
    .main_axis_i(ma), .sub1_axis_i(s1), .sub2_axis_i(s2), .spd_mode_i(md),
    .op_speed_i(sp), .op_method_i(om), .blend_en_i(bl), .arc_dist_i(ad),
    .cur_x_i(cx), .cur_y_i(cy), .cur_z_i(cz), .goal_x_i(gx), .goal_y_i(gy),
    .goal_z_i(gz), .next_x_i(nx), .next_y_i(ny), .busy_o(bz), .done_o(dn),
    .err_code_o(ec), .rate_x_o(rx), .rate_y_o(ry), .rate_z_o(rz),
    .path_speed_o(ps), .dir_fwd_o(df), .three_axis_o(t3), .arc_en_o(ae),
    .arc_sx_o(asx), .arc_sy_o(asy), .arc_ex_o(aex), .arc_ey_o(aey));
  drive_model mot (.clk_i(clk_i), .done_i(dn), .rate_i(ry), .seen_o(my));
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Start is a one-cycle request; the wait for done is bounded
  task run(input [1:0] s);
    integer n;
    begin
      @(posedge clk_i) st <= s;
      @(posedge clk_i) st <= 2'h0;
      for (n = 0; n < 60 && dn !== 1'b1; n = n + 1) @(negedge clk_i);
      if (dn !== 1'b1) begin
        err_count = err_count + 1;
        print_verdict;
      end
    end
  endtask
  task lin(input m, input [31:0] v, x0, y0, x1, y1, ex, ey, ep);
    begin
      @(posedge clk_i);
      md <= m; sp <= v; cx <= x0; cy <= y0; gx <= x1; gy <= y1;
      run(`START_IND);
      chk(rx, ex);
      chk(ry, ey);
      chk(ps, ep);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Host keeps every speed below the drive limit
    lin(0, 400, 2000, 1000, 6000, 4000, 400, 300, 500);
    chk(32'(df), 32'h3);
    @(negedge clk_i) chk(my, 32'h12C);
    lin(1, 400, 2000, 1000, 6000, 4000, 320, 240, 400);
    lin(0, 1000, 5000, 1000, 5000, 3000, 0, 1000, 1000);
    lin(0, 400, 6000, 4000, 2000, 1000, 400, 300, 500);
    chk(32'(df), 32'h0);
    $display("speed tests done");
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clk_i) s1 <= (i == 2) ? 3'h5 : i[2:0];
      run(`START_SYNC);
      chk(32'(ec), 32'hFD);
    end
    @(posedge clk_i) st <= 2'h3;
    s1 <= 3'h2;
    repeat (4) @(negedge clk_i);
    chk(32'(bz), 32'h0);
    @(posedge clk_i) st <= 2'h0;
    s2 <= 3'h3; cz <= 1000; gz <= 7000;
    lin(0, 1000, 2000, 1000, 5000, 7000, 1000, 2000, 3000);
    chk(rz, 32'h7D0);
    chk({28'h0, t3, df}, 32'hF);
    @(posedge clk_i) s2 <= 3'h0;
    run(`START_IND);
    chk(32'(t3), 32'h0);
    $display("axis tests done");
    @(posedge clk_i) cz <= 0; gz <= 0; om <= `OPM_CONT; bl <= 1'b1;
    ad <= 2000; nx <= 5000; ny <= 4000;
    lin(0, 3000, 0, 1000, 5000, 1000, 3000, 0, 3000);
    chk(32'(ae), 32'h1);
    chk(asx, 32'hBB8);
    chk(asy, 32'h3E8);
    chk(aex, 32'h1388);
    chk(aey, 32'hBB8);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk_i) om <= (i < 2) ? i[1:0] : `OPM_CONT;
      bl <= (i != 2); ad <= (i == 4) ? 6000 : 2000;
      nx <= (i == 3) ? 9000 : 5000;
      ny <= (i == 3) ? 1000 : (i == 5) ? 2000 : 4000;
      run(`START_IND);
      chk(32'(ae), 32'h0);
      chk(32'(ec), (i >= 4) ? 32'h106 : 32'h0);
    end
    $display("blend tests done");
    print_verdict;
  end
endmodule
`default_nettype wire
